// file: design/wdg_consts.svh
// Watchdog register offsets, field positions, reset values and counts
// What this block does
// - Reset-enable bit reads one while the watchdog reset flag stays set.
// - Four-bit timeout select: control bit 5 on top, bits 2..0 below.
// - Time-out after 2048 oscillator cycles, doubling per step, up to 67108864.
// - A time-out in reset mode, or in irq-then-reset mode with the irq flag set, issues a system reset, like pin, power-on, brown-out.
// - Time-out counted in watchdog oscillator cycles, not system clock cycles.
// - Change-unlock bit clears itself four clocks after software sets it.
// - Mode from reset-enable and irq-enable; forced-reset fuse imposes reset mode.
// - Watchdog reset flag set by watchdog reset, cleared by power-on or zero write.
// - Timeout irq flag set in irq modes, cleared by vector or one write.
`ifndef WDG_CONSTS_SVH
`define WDG_CONSTS_SVH

`define WDG_OFF_CTRL 12'h000
`define WDG_OFF_CAUSE 12'h004
`define WDG_OFF_RESTART 12'h008
`define WDG_OFF_STATUS 12'h00C
`define WDG_OFF_MASK 12'h010
`define WDG_OFF_COUNT 12'h014

`define WDG_CTRL_IRQF 7
`define WDG_CTRL_IRQE 6
`define WDG_CTRL_SEL3 5
`define WDG_CTRL_UNLOCK 4
`define WDG_CTRL_RSTEN 3
`define WDG_CTRL_SEL_HI 2

`define WDG_CAUSE_WATCHDOG_RESET_FLAG 3
`define WDG_CAUSE_BORF 2
`define WDG_CAUSE_EXTRF 1

`define WDG_EVT_IRQ 0
`define WDG_EVT_RST 1

`define WDG_CAUSE_RST 4'h1
`define WDG_MASK_RST 2'h0

`define WDG_UNLOCK_CYC 3'h4
`define WDG_BASE_TICKS 32'h0000_0800

`endif

// file: design/wdg_pkg.sv
// Watchdog types: modes and state records
package wdg_pkg;

  typedef enum logic [1:0] {
    wdg_stopped,
    wdg_irq_only,
    wdg_reset_only,
    wdg_irq_then_reset
  } wdg_mode_e;

  typedef struct packed {
    logic irqf;
    logic irqe;
    logic rsten;
    logic [3:0] sel;
    logic [2:0] unlock_cnt;
    logic [3:0] cause;
    logic [25:0] count;
    logic [1:0] evt;
    logic [1:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic irq_req;
    logic sys_reset;
  } wdg_state_s;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic osc_d;
    logic tick;
  } wdg_sync_state_s;

endpackage

// file: design/wdg_pin_sync.sv
// Two-stage synchroniser for the oscillator and fuse pins, with tick detect
`timescale 1ns/1ps
module wdg_pin_sync
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] pins,
  output logic [1:0] levels,
  output logic osc_tick
);
  wdg_pkg::wdg_sync_state_s st_r;
  wdg_pkg::wdg_sync_state_s st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.osc_d = st_r.s2[0];
    // One tick per oscillator rising edge
    st_nxt.tick = st_r.s2[0] & ~st_r.osc_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign levels = st_r.s2;
  assign osc_tick = st_r.tick;
endmodule // wdg_pin_sync

// file: design/wdg_top.sv
// Watchdog timer with time-out control, reset cause flags and APB registers
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "wdg_consts.svh"
module wdg_top
#(
  parameter int unsigned BASE_TICKS = `WDG_BASE_TICKS
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wdg_osc_pin,
  input wire logic forced_reset_fuse,
  input wire logic wdr_exec,
  input wire logic irq_vector_ack,
  input wire logic ext_reset_seen,
  input wire logic brownout_seen,
  output logic sys_reset_req,
  output logic timeout_irq_req,
  output logic irq
);
  wdg_pkg::wdg_state_s st_r;
  wdg_pkg::wdg_state_s st_nxt;
  wdg_pkg::wdg_mode_e mode;
  logic [1:0] pin_lvl;
  logic osc_tick;
  logic fuse_s;
  logic acc;
  logic wr;
  logic rd;
  logic timeout;
  logic [26:0] last;

  wdg_pin_sync u_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .pins({forced_reset_fuse, wdg_osc_pin}),
    .levels(pin_lvl),
    .osc_tick(osc_tick)
  );

  assign fuse_s = pin_lvl[1];

  function automatic wdg_pkg::wdg_mode_e mode_of(input logic fuse, input logic rsten,
                                                 input logic irqe);
    if (fuse)
      return wdg_pkg::wdg_reset_only;
    unique case ({rsten, irqe})
      2'b00: return wdg_pkg::wdg_stopped;
      2'b01: return wdg_pkg::wdg_irq_only;
      2'b10: return wdg_pkg::wdg_reset_only;
      2'b11: return wdg_pkg::wdg_irq_then_reset;
    endcase
  endfunction

  function automatic logic [26:0] limit_of(input logic [3:0] s);
    limit_of = 27'(BASE_TICKS) << s;
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `WDG_OFF_CTRL) || (a == `WDG_OFF_CAUSE) || (a == `WDG_OFF_RESTART) ||
             (a == `WDG_OFF_STATUS) || (a == `WDG_OFF_MASK) || (a == `WDG_OFF_COUNT);
  endfunction

  function automatic logic [31:0] read_word(input wdg_pkg::wdg_state_s s,
                                            input logic [11:0] a);
    read_word = 32'h0000_0000;
    unique case (a)
      `WDG_OFF_CTRL:
      begin
        read_word[`WDG_CTRL_IRQF] = s.irqf;
        read_word[`WDG_CTRL_IRQE] = s.irqe;
        read_word[`WDG_CTRL_SEL3] = s.sel[3];
        read_word[`WDG_CTRL_UNLOCK] = (s.unlock_cnt != 3'h0);
        read_word[`WDG_CTRL_RSTEN] = s.rsten;
        read_word[`WDG_CTRL_SEL_HI:0] = s.sel[2:0];
      end
      `WDG_OFF_CAUSE: read_word[3:0] = s.cause;
      `WDG_OFF_STATUS: read_word[1:0] = s.evt;
      `WDG_OFF_MASK: read_word[1:0] = s.mask;
      `WDG_OFF_COUNT: read_word[25:0] = s.count;
      default: read_word = 32'h0000_0000;
    endcase
  endfunction

  assign mode = mode_of(fuse_s, st_r.rsten, st_r.irqe);
  assign acc = psel & penable & st_r.pready;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign last = limit_of(st_r.sel) - 27'h000_0001;
  assign timeout = osc_tick && (mode != wdg_pkg::wdg_stopped) && !wdr_exec &&
                   ({1'b0, st_r.count} == last);

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    st_nxt.sys_reset = 1'b0;

    if (st_r.unlock_cnt != 3'h0)
      st_nxt.unlock_cnt = st_r.unlock_cnt - 3'h1;

    // Counting in oscillator ticks only
    if (mode == wdg_pkg::wdg_stopped || wdr_exec)
      st_nxt.count = 26'h000_0000;
    else if (timeout)
      st_nxt.count = 26'h000_0000;
    else if (osc_tick)
      st_nxt.count = st_r.count + 26'h000_0001;

    if (wr && paddr == `WDG_OFF_CTRL)
    begin
      st_nxt.irqe = pwdata[`WDG_CTRL_IRQE];
      if (pwdata[`WDG_CTRL_IRQF])
        st_nxt.irqf = 1'b0;
      if (pwdata[`WDG_CTRL_UNLOCK])
      begin
        st_nxt.unlock_cnt = `WDG_UNLOCK_CYC;
        st_nxt.rsten = st_r.rsten | pwdata[`WDG_CTRL_RSTEN];
      end
      else if (st_r.unlock_cnt != 3'h0)
      begin
        // Open window: clearing reset-enable and a new select are accepted
        st_nxt.rsten = pwdata[`WDG_CTRL_RSTEN];
        st_nxt.sel = {pwdata[`WDG_CTRL_SEL3], pwdata[`WDG_CTRL_SEL_HI:0]};
        st_nxt.unlock_cnt = 3'h0;
      end
      else
        st_nxt.rsten = st_r.rsten | pwdata[`WDG_CTRL_RSTEN];
    end
    if (wr && paddr == `WDG_OFF_CAUSE)
      st_nxt.cause = st_r.cause & pwdata[3:0];
    if (wr && paddr == `WDG_OFF_RESTART)
      st_nxt.count = 26'h000_0000;
    if (wr && paddr == `WDG_OFF_MASK)
      st_nxt.mask = pwdata[1:0];
    // Only the bits actually returned are cleared, so nothing is lost
    if (rd && paddr == `WDG_OFF_STATUS)
      st_nxt.evt = st_r.evt & ~st_r.prdata[1:0];

    if (irq_vector_ack)
    begin
      st_nxt.irqf = 1'b0;
      // Vector taken drops back to plain reset mode
      if (mode == wdg_pkg::wdg_irq_then_reset)
        st_nxt.irqe = 1'b0;
    end

    // Hardware sets come last so they win over clears
    if (timeout)
    begin
      unique case (mode)
        wdg_pkg::wdg_irq_only:
          st_nxt.irqf = 1'b1;
        wdg_pkg::wdg_reset_only:
          st_nxt.sys_reset = 1'b1;
        wdg_pkg::wdg_irq_then_reset:
          if (st_r.irqf)
            st_nxt.sys_reset = 1'b1;
          else
            st_nxt.irqf = 1'b1;
        wdg_pkg::wdg_stopped:
          st_nxt.sys_reset = 1'b0;
      endcase
    end
    if (st_nxt.sys_reset)
    begin
      st_nxt.cause[`WDG_CAUSE_WATCHDOG_RESET_FLAG] = 1'b1;
      st_nxt.evt[`WDG_EVT_RST] = 1'b1;
    end
    if (timeout && st_nxt.irqf && !st_r.irqf)
      st_nxt.evt[`WDG_EVT_IRQ] = 1'b1;
    if (ext_reset_seen || brownout_seen)
      st_nxt.count = 26'h000_0000;
    if (ext_reset_seen)
      st_nxt.cause[`WDG_CAUSE_EXTRF] = 1'b1;
    if (brownout_seen)
      st_nxt.cause[`WDG_CAUSE_BORF] = 1'b1;

    // Flag held: software cannot drop reset-enable
    st_nxt.rsten = st_nxt.rsten | st_nxt.cause[`WDG_CAUSE_WATCHDOG_RESET_FLAG];

    if (psel && !penable)
    begin
      st_nxt.pready = 1'b1;
      st_nxt.prdata = read_word(st_r, paddr);
      st_nxt.pslverr = !mapped(paddr);
    end
    st_nxt.irq = |(st_nxt.evt & st_nxt.mask);
    st_nxt.irq_req = st_nxt.irqf & st_nxt.irqe;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
      st_r.cause <= `WDG_CAUSE_RST;
      st_r.mask <= `WDG_MASK_RST;
    end
    else
      st_r <= st_nxt;
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign sys_reset_req = st_r.sys_reset;
  assign timeout_irq_req = st_r.irq_req;
  assign irq = st_r.irq;

  rsten_forced_a: assert property (
    @(posedge pclk) disable iff (!presetn) st_r.cause[`WDG_CAUSE_WATCHDOG_RESET_FLAG] |-> st_r.rsten)
    else $error("reset enable low while watchdog reset flag set");

  sel_locked_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_r.unlock_cnt == 3'h0) |=> (st_r.sel == $past(st_r.sel)))
    else $error("timeout select changed outside unlock window");

  wrap_point_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    timeout |=> (st_r.count == 26'h000_0000) && (st_r.sys_reset || st_r.irqf))
    else $error("time-out did not restart count or act");

  reset_cause_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_r.sys_reset |-> st_r.cause[`WDG_CAUSE_WATCHDOG_RESET_FLAG] && !$past(st_r.sys_reset))
    else $error("system reset without watchdog flag or too long");

  tick_only_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_r.count == $past(st_r.count) + 26'h000_0001) |-> $past(osc_tick))
    else $error("count advanced without oscillator tick");

  unlock_close_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_r.unlock_cnt == `WDG_UNLOCK_CYC) && !wr ##1 !wr ##1 !wr ##1 !wr |=>
      (st_r.unlock_cnt == 3'h0))
    else $error("change unlock not closed after four clocks");

  fuse_mode_a: assert property (
    @(posedge pclk) disable iff (!presetn) timeout && fuse_s |=> st_r.sys_reset)
    else $error("fuse did not force reset on time-out");

  watchdog_reset_flag_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(st_r.cause[`WDG_CAUSE_WATCHDOG_RESET_FLAG]) |-> $past(wr && paddr == `WDG_OFF_CAUSE))
    else $error("watchdog reset flag cleared without write");

  irq_flag_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    timeout && (mode == wdg_pkg::wdg_irq_only) |=>
      st_r.irqf && (st_r.irq_req == st_r.irqe))
    else $error("timeout flag not set in interrupt mode");

  restart_a: assert property (
    @(posedge pclk) disable iff (!presetn) wdr_exec |=> (st_r.count == 26'h000_0000))
    else $error("restart did not clear count");
endmodule // wdg_top

// file: tb/wdg_top_test.sv
// Bench for the watchdog: APB master, oscillator stimulus, time-out model
`timescale 1ns/1ps
`include "wdg_consts.svh"
module wdg_top_test;
  logic pclk, presetn, psel, penable, pwrite, osc, fuse, wdr, ack, extr, bor;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, srst, irqreq, irq;
  int num_errors, tests_run, nrst, cyc, per;
  wdg_top #(.BASE_TICKS(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wdg_osc_pin(osc), .forced_reset_fuse(fuse),
    .wdr_exec(wdr), .irq_vector_ack(ack), .ext_reset_seen(extr), .brownout_seen(bor),
    .sys_reset_req(srst), .timeout_irq_req(irqreq), .irq(irq));
  initial
  begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard: whole run needs a few hundred cycles
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      num_errors++;
      close_out();
    end
  end
  // Pulse counted mid-cycle, away from the edge that launches it
  always @(negedge pclk)
    if (srst === 1'b1)
      nrst <= nrst + 1;
  task automatic chk(string what, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Answer looked at where settled; the transfer ends on the next rising edge
    do
    begin
      @(negedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdchk(string what, logic [11:0] a, logic [31:0] e);
    apb(0, a, 0);
    chk(what, e, rd);
  endtask
  // Oscillator far slower than pclk so the synchroniser sees every edge
  task automatic ticks(int n);
    repeat (n)
    begin
      osc <= 1;
      repeat (4 + $urandom % 3) @(posedge pclk);
      osc <= 0;
      repeat (4 + $urandom % 3) @(posedge pclk);
    end
  endtask
  // Restart, then expect r resets on the last tick of a period, none before
  task automatic period(int r, int pre);
    int n0;
    ticks(pre);
    wdr <= 1;
    @(posedge pclk);
    wdr <= 0;
    n0 = nrst;
    ticks(per - 1);
    chk("early reset", n0, nrst);
    ticks(1);
    repeat (3) @(posedge pclk);
    chk("reset count", n0 + r, nrst);
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, osc, fuse, wdr, ack, extr, bor} = 0;
    paddr = 0;
    pwdata = 0;
    {cyc, nrst, num_errors, tests_run} = 0;
    void'($urandom(66739));
    repeat (8) @(posedge pclk);
    presetn <= 1;
    rdchk("cause", `WDG_OFF_CAUSE, 32'h0000_0001);
    rdchk("ctrl", `WDG_OFF_CTRL, 32'h0000_0000);
    apb(0, 12'h0FC, 32'h0000_0000);
    chk("slverr", 1, err);
    chk("unmapped", 0, rd);
    per = 4;
    period(0, 0);
    apb(1, `WDG_OFF_CTRL, 32'h0000_0040);
    period(0, 0);
    rdchk("flag", `WDG_OFF_CTRL, 32'h0000_00C0);
    chk("irq masked", 0, irq);
    chk("irq req", 1, irqreq);
    apb(1, `WDG_OFF_MASK, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk("irq", 1, irq);
    rdchk("status", `WDG_OFF_STATUS, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk("irq clr", 0, irq);
    apb(1, `WDG_OFF_CTRL, 32'h0000_00C0);
    rdchk("flag clr", `WDG_OFF_CTRL, 32'h0000_0040);
    apb(1, `WDG_OFF_CTRL, 32'h0000_0048);
    period(0, 0);
    rdchk("both", `WDG_OFF_CTRL, 32'h0000_00C8);
    ack <= 1;
    @(posedge pclk);
    ack <= 0;
    rdchk("ack", `WDG_OFF_CTRL, 32'h0000_0008);
    period(1, 0);
    rdchk("cause wd", `WDG_OFF_CAUSE, 32'h0000_0009);
    apb(1, `WDG_OFF_CTRL, 32'h0000_0018);
    apb(1, `WDG_OFF_CTRL, 32'h0000_0000);
    rdchk("forced", `WDG_OFF_CTRL, 32'h0000_0008);
    apb(1, `WDG_OFF_CAUSE, 32'h0000_0000);
    apb(1, `WDG_OFF_CTRL, 32'h0000_0018);
    apb(1, `WDG_OFF_CTRL, 32'h0000_0001);
    rdchk("unlocked", `WDG_OFF_CTRL, 32'h0000_0001);
    per = 8;
    fuse <= 1;
    period(1, 0);
    fuse <= 0;
    apb(1, `WDG_OFF_CAUSE, 32'h0000_0000);
    apb(1, `WDG_OFF_CTRL, 32'h0000_0018);
    rdchk("open", `WDG_OFF_CTRL, 32'h0000_0019);
    repeat (6) @(posedge pclk);
    apb(1, `WDG_OFF_CTRL, 32'h0000_0000);
    rdchk("closed", `WDG_OFF_CTRL, 32'h0000_0009);
    period(1, 5);
    extr <= 1;
    bor <= 1;
    @(posedge pclk);
    {extr, bor} <= 0;
    rdchk("causes", `WDG_OFF_CAUSE, 32'h0000_000E);
    rdchk("status both", `WDG_OFF_STATUS, 32'h0000_0003);
    ticks(2);
    apb(1, `WDG_OFF_RESTART, 32'h0000_0000);
    ticks(3);
    rdchk("count", `WDG_OFF_COUNT, 32'h0000_0003);
    close_out();
  end
endmodule // wdg_top_test
